// [core/ldsp_pkg.sv]
// Purpose: Shared constants and types of the loop converter serial port.
// Assumes: 100 MHz system clock, classic Wishbone register access.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package ldsp_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
	localparam int unsigned SCLK_MAX_MHZ  = 30;
	localparam int unsigned LOSS_TIME_MS  = 100;
	localparam int unsigned LOSS_CYCLES   = LOSS_TIME_MS * (CLK_FREQ_HZ / 1000);

	// ----------------------------------------------------------------
	// Frame format
	// ----------------------------------------------------------------
	localparam int unsigned FRAME_W       = 24;
	localparam int unsigned PEC_W         = 8;
	localparam int unsigned FRAME_PEC_W   = FRAME_W + PEC_W;
	localparam int unsigned VALUE_W       = 16;
	localparam int unsigned CNT_W         = 6;
	localparam logic [7:0]  PEC_POLY      = 8'h07;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_INPUT     = 8'h08;
	localparam logic [7:0]  OFS_CONV      = 8'h0C;
	localparam logic [7:0]  OFS_READBACK  = 8'h10;
	localparam logic [7:0]  OFS_FRAMES    = 8'h14;
	localparam logic [7:0]  OFS_LASTFRAME = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_PEC_EN_BIT   = 0;
	localparam int unsigned CTRL_LOSS_EN_BIT  = 1;
	localparam int unsigned STAT_FAULT_LSB    = 0;
	localparam int unsigned STAT_STRAP_LSB    = 8;
	localparam int unsigned STAT_FAULT_O_BIT  = 16;
	localparam int unsigned STAT_PEND_BIT     = 17;
	localparam logic [1:0]  CTRL_RESET        = 2'h2;
	localparam logic [31:0] READBACK_RESET    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic overtemp;
		logic loop_voltage;
		logic loop_current;
		logic packet_error_check;
		logic loss_of_control;
	} ldsp_fault_t;

	typedef struct packed {
		logic       span_select_bit1;
		logic       span_select_bit0;
		logic       set_resistor_select;
		logic       alarm_upscale;
	} ldsp_strap_t;

	typedef struct packed {
		logic overtemp;
		logic loop_voltage;
		logic loop_current;
	} ldsp_analog_t;

endpackage

// [core/ldsp_sync.sv]
// Purpose: Two flip-flop synchroniser for levels entering the system clock.
// Assumes: Each bit is an independent slow level.
// Notes:   The first stage is read by the second stage only.
module ldsp_sync #(
	parameter int unsigned W             = 1,
	parameter logic [W-1:0] RESET_VAL    = '0
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule

// [core/ldsp_top.sv]
// Purpose: Serial port, load control, fault output and straps of a loop converter.
// Assumes: Serial clock idles high; frame select high between frames.
// Notes:   Serial logic runs on the serial clock; frames cross on frame select.
module ldsp_top
	import ldsp_pkg::*;
#(
	parameter int unsigned LOSS_COUNT = ldsp_pkg::LOSS_CYCLES,
	parameter int unsigned FRAME_BITS = ldsp_pkg::FRAME_W,
	parameter int unsigned VALUE_BITS = ldsp_pkg::VALUE_W
) (
	// System clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// Serial link
	input  wire logic                     sclk_i,
	input  wire logic                     frame_sel_n_i,
	input  wire logic                     serial_data_in_i,
	output logic                          serial_data_out_o,
	// Load and fault pins
	input  wire logic                     output_load_n_i,
	output logic                          fault_o,
	// Analog fault detectors and straps
	input  wire ldsp_pkg::ldsp_analog_t   analog_fault_i,
	input  wire ldsp_pkg::ldsp_strap_t    strap_i,
	output ldsp_pkg::ldsp_strap_t         strap_o,
	// Converter value
	output logic      [VALUE_BITS-1:0]    conv_value_o
);

	import ldsp_pkg::*;

	// ----------------------------------------------------------------
	// Serial clock domain: receive
	// ----------------------------------------------------------------
	logic [FRAME_PEC_W-1:0] rx_shift_reg;
	logic [CNT_W-1:0]       rx_cnt_reg;
	logic                   rx_fresh_reg;
	logic                   tx_fresh_reg;
	logic [CNT_W-1:0]       tx_idx_reg;
	logic                   sdo_reg;
	logic [31:0]            tx_word_reg;
	logic [CNT_W-1:0]       rx_cnt_next;
	logic [CNT_W-1:0]       tx_idx_next;
	wire  [CNT_W-1:0]       cnt_max = CNT_W'(FRAME_PEC_W);

	// Frame select high sets the fresh flags, so a new frame restarts counting.
	always_ff @(negedge sclk_i or posedge frame_sel_n_i) begin
		if (frame_sel_n_i) begin
			rx_fresh_reg <= 1'b1;
		end else begin
			rx_fresh_reg <= 1'b0;
		end
	end

	assign rx_cnt_next = rx_fresh_reg ? CNT_W'(1) :
		((rx_cnt_reg == cnt_max) ? rx_cnt_reg : rx_cnt_reg + CNT_W'(1));

	// Shifting happens only inside an active frame.
	always_ff @(negedge sclk_i) begin
		if (!frame_sel_n_i) begin
			rx_shift_reg <= {rx_shift_reg[FRAME_PEC_W-2:0], serial_data_in_i};
			rx_cnt_reg   <= rx_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Serial clock domain: transmit
	// ----------------------------------------------------------------
	always_ff @(posedge sclk_i or posedge frame_sel_n_i) begin
		if (frame_sel_n_i) begin
			tx_fresh_reg <= 1'b1;
		end else begin
			tx_fresh_reg <= 1'b0;
		end
	end

	assign tx_idx_next = tx_fresh_reg ? CNT_W'(0) :
		((tx_idx_reg == CNT_W'(31)) ? tx_idx_reg : tx_idx_reg + CNT_W'(1));

	// Output bit changes on the rising edge and holds through the next fall.
	always_ff @(posedge sclk_i) begin
		if (!frame_sel_n_i) begin
			tx_idx_reg <= tx_idx_next;
			sdo_reg    <= tx_word_reg[5'(31 - tx_idx_next)];
		end
	end

	assign serial_data_out_o = sdo_reg;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic          frame_sel_n_s;
	logic          load_n_s;
	ldsp_analog_t  analog_s;
	ldsp_strap_t   strap_s;

	ldsp_sync #(.W(2), .RESET_VAL(2'h3)) u_sync_ctl (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({frame_sel_n_i, output_load_n_i}),
		.sync_o  ({frame_sel_n_s, load_n_s})
	);

	ldsp_sync #(.W(7), .RESET_VAL(7'h00)) u_sync_lvl (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({analog_fault_i, strap_i}),
		.sync_o  ({analog_s, strap_s})
	);

	// ----------------------------------------------------------------
	// Frame completion in the system clock
	// ----------------------------------------------------------------
	logic                   frame_d_reg;
	logic                   load_d_reg;
	wire                    frame_end  = frame_sel_n_s & ~frame_d_reg;
	wire                    load_fall  = ~load_n_s & load_d_reg;
	wire                    len_plain  = (rx_cnt_reg == CNT_W'(FRAME_W));
	wire                    len_pec    = (rx_cnt_reg == CNT_W'(FRAME_PEC_W));
	logic [1:0]             ctrl_reg;
	wire                    pec_en     = ctrl_reg[CTRL_PEC_EN_BIT];
	wire                    loss_en    = ctrl_reg[CTRL_LOSS_EN_BIT];
	wire  [FRAME_W-1:0]     frame_word = len_pec ? rx_shift_reg[FRAME_PEC_W-1:PEC_W] :
		rx_shift_reg[FRAME_W-1:0];

	// Checksum over the frame body, most significant bit first.
	function automatic logic [7:0] pec_calc(input logic [FRAME_W-1:0] data);
		logic [7:0] crc;
		crc = 8'h00;
		for (int i = FRAME_W - 1; i >= 0; i--) begin
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ data[i]) ? PEC_POLY : 8'h00);
		end
		return crc;
	endfunction

	wire pec_ok    = (pec_calc(frame_word) == rx_shift_reg[PEC_W-1:0]);
	wire frame_ok  = pec_en ? (len_pec & pec_ok) : (len_plain | len_pec);
	wire frame_bad = frame_end & ~frame_ok;
	wire frame_act = frame_end & frame_ok;

	// ----------------------------------------------------------------
	// Input and converter registers
	// ----------------------------------------------------------------
	logic [VALUE_BITS-1:0] input_reg;
	logic [VALUE_BITS-1:0] conv_reg;
	logic [FRAME_W-1:0]    last_frame_reg;
	logic                  pending_reg;
	logic [31:0]           frames_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_d_reg <= 1'b1;
			load_d_reg  <= 1'b1;
		end else begin
			frame_d_reg <= frame_sel_n_s;
			load_d_reg  <= load_n_s;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_reg      <= '0;
			conv_reg       <= '0;
			last_frame_reg <= '0;
			pending_reg    <= 1'b0;
			frames_reg     <= '0;
		end else if (frame_act) begin
			input_reg      <= frame_word[VALUE_BITS-1:0];
			last_frame_reg <= frame_word;
			frames_reg     <= frames_reg + 32'h0000_0001;
			if (!load_n_s) begin
				conv_reg    <= frame_word[VALUE_BITS-1:0];
				pending_reg <= 1'b0;
			end else begin
				pending_reg <= 1'b1;
			end
		end else if (load_fall) begin
			conv_reg    <= input_reg;
			pending_reg <= 1'b0;
		end
	end

	assign conv_value_o = conv_reg;

	// ----------------------------------------------------------------
	// Loss of interface control
	// ----------------------------------------------------------------
	logic [31:0] idle_cnt_reg;
	wire         idle_expired = (idle_cnt_reg >= LOSS_COUNT);

	always_ff @(posedge clk_i) begin
		if (rst_i || frame_act || !loss_en) begin
			idle_cnt_reg <= '0;
		end else if (!idle_expired) begin
			idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Fault flags and fault output
	// ----------------------------------------------------------------
	ldsp_fault_t fault_reg;
	ldsp_fault_t fault_set;
	ldsp_fault_t fault_clr;
	logic        fault_o_reg;

	assign fault_set.loss_of_control    = loss_en & idle_expired;
	assign fault_set.packet_error_check = frame_bad;
	assign fault_set.loop_current       = analog_s.loop_current;
	assign fault_set.loop_voltage       = analog_s.loop_voltage;
	assign fault_set.overtemp           = analog_s.overtemp;

	// A flag set in the same cycle as its clear stays set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_reg   <= '0;
			fault_o_reg <= 1'b0;
		end else begin
			fault_reg   <= (fault_reg & ~fault_clr) | fault_set;
			fault_o_reg <= |((fault_reg & ~fault_clr) | fault_set);
		end
	end

	assign fault_o = fault_o_reg;

	// ----------------------------------------------------------------
	// Straps
	// ----------------------------------------------------------------
	ldsp_strap_t strap_reg;
	logic [1:0]  strap_age_reg;
	wire         strap_take = (strap_age_reg == 2'h2);

	// Straps are caught once, after the synchroniser has refilled following reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_reg     <= '0;
			strap_age_reg <= 2'h0;
		end else begin
			if (strap_age_reg != 2'h3) begin
				strap_age_reg <= strap_age_reg + 2'h1;
			end
			if (strap_take) begin
				strap_reg <= strap_s;
			end
		end
	end

	assign strap_o = strap_reg;

	// ----------------------------------------------------------------
	// Readback word handed to the serial domain between frames
	// ----------------------------------------------------------------
	logic [31:0] readback_reg;
	logic [31:0] rb_pending_reg;
	logic        rb_dirty_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_word_reg <= READBACK_RESET;
		end else if (frame_sel_n_s && frame_d_reg && rb_dirty_reg) begin
			tx_word_reg <= rb_pending_reg;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone decode
	// ----------------------------------------------------------------
	logic        ack_reg;
	logic [31:0] dat_reg;
	wire         wb_req    = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire         wb_wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	wire         sel_ctrl  = (wb_adr_i == OFS_CTRL);
	wire         sel_stat  = (wb_adr_i == OFS_STATUS);
	wire         sel_rb    = (wb_adr_i == OFS_READBACK);
	wire  [31:0] wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire  [31:0] wbits     = wb_dat_i & wmask;
	wire  [31:0] rb_merge  = (readback_reg & ~wmask) | wbits;
	wire  [31:0] stat_word = {14'h0000, pending_reg, fault_o_reg, 4'h0, strap_reg, 3'h0, fault_reg};
	wire  [31:0] rd_word   =
		(wb_adr_i == OFS_CTRL)      ? {30'h0000_0000, ctrl_reg} :
		(wb_adr_i == OFS_STATUS)    ? stat_word :
		(wb_adr_i == OFS_INPUT)     ? 32'(input_reg) :
		(wb_adr_i == OFS_CONV)      ? 32'(conv_reg) :
		(wb_adr_i == OFS_READBACK)  ? readback_reg :
		(wb_adr_i == OFS_FRAMES)    ? frames_reg :
		(wb_adr_i == OFS_LASTFRAME) ? 32'(last_frame_reg) : 32'h0000_0000;

	assign fault_clr = (wb_wr && sel_stat) ? ldsp_fault_t'(wbits[4:0]) : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= wb_req;
			dat_reg <= wb_req ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wb_wr && sel_ctrl && wb_sel_i[0]) begin
			ctrl_reg <= wb_dat_i[1:0];
		end
	end

	// Software writes wait for a gap between frames before reaching the link.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			readback_reg   <= READBACK_RESET;
			rb_pending_reg <= READBACK_RESET;
			rb_dirty_reg   <= 1'b0;
		end else if (wb_wr && sel_rb) begin
			readback_reg   <= rb_merge;
			rb_pending_reg <= rb_merge;
			rb_dirty_reg   <= 1'b1;
		end else if (frame_sel_n_s && frame_d_reg) begin
			rb_dirty_reg   <= 1'b0;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

endmodule

// [verif/ldsp_host_model.sv]
// Purpose: Host controller that drives serial frames and reads back data.
// Assumes: Serial clock idles high; junk cycles may run it before frame select falls.
// Notes:   Half period is chosen per frame for prompt or slow hosts.
module ldsp_host_model (
	// Serial link
	output logic      sclk_o,
	output logic      frame_sel_n_o,
	output logic      serial_data_in_o,
	input  wire logic serial_data_out_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_o = 1'b1;
		frame_sel_n_o = 1'b1;
		serial_data_in_o = 1'b0;
	end
	// Sends the low n bits of d, most significant first.
	task automatic frame(input logic [31:0] d, input int n, input int half, input int junk,
		output logic [31:0] rd);
		rd = 32'h0;
		for (int i = 0; i < junk; i++) begin
			#half sclk_o = 1'b0;
			#half sclk_o = 1'b1;
		end
		#half frame_sel_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in_o = d[i];
			#half rd = {rd[30:0], serial_data_out_i};
			sclk_o = 1'b0;
			#half sclk_o = 1'b1;
		end
		#half frame_sel_n_o = 1'b1;
		serial_data_in_o = ~serial_data_in_o;
		#100;
	endtask
endmodule

// [verif/ldsp_top_properties.sv]
// Purpose: Assertions on the pins of the loop converter serial port.
// Assumes: One system clock domain with synchronous reset rst_i.
// Notes:   Straps change only while the bench holds reset.
module ldsp_top_properties
	import ldsp_pkg::*;
(
	// Clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	// Bus
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	// Pins
	input wire logic                  frame_sel_n_i,
	input wire logic                  output_load_n_i,
	input wire logic                  fault_o,
	input wire ldsp_pkg::ldsp_analog_t analog_fault_i,
	input wire ldsp_pkg::ldsp_strap_t  strap_i,
	input wire ldsp_pkg::ldsp_strap_t  strap_o,
	input wire logic [15:0]           conv_value_o
);
	// ------------------------------------------------
	// Counters since reset and since the last frame end or load fall
	// ------------------------------------------------
	logic [3:0] rst_cnt_reg;
	logic [3:0] evt_cnt_reg;
	logic       sel_prev_reg;
	logic       load_prev_reg;
	wire        evt = (frame_sel_n_i & ~sel_prev_reg) | (~output_load_n_i & load_prev_reg);
	always_ff @(posedge clk_i) begin
		sel_prev_reg <= frame_sel_n_i;
		load_prev_reg <= output_load_n_i;
		rst_cnt_reg <= rst_i ? 4'h0 : rst_cnt_reg + {3'h0, rst_cnt_reg != 4'hF};
		evt_cnt_reg <= rst_i ? 4'hF : evt ? 4'h0 : evt_cnt_reg + {3'h0, evt_cnt_reg != 4'hF};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	conv_cause_a: assert property ($changed(conv_value_o) |-> evt_cnt_reg <= 4'hA)
		else $error("converter changed without frame end or load fall");
	conv_hold_a: assert property (output_load_n_i [*6] |-> $stable(conv_value_o))
		else $error("converter changed while load high");
	fault_set_a: assert property ((analog_fault_i != 3'h0) [*5] |-> fault_o)
		else $error("fault output low with detector active");
	fault_keep_a: assert property (fault_o && analog_fault_i != 3'h0 |=> fault_o)
		else $error("fault output dropped with detector active");
	strap_take_a: assert property (rst_cnt_reg == 4'h6 |-> strap_o == strap_i)
		else $error("strap capture wrong");
	strap_hold_a: assert property (rst_cnt_reg > 4'h6 |-> $stable(strap_o))
		else $error("straps changed after capture");
	cover property (evt && frame_sel_n_i);
	cover property (evt && !output_load_n_i);
	cover property ($rose(fault_o));
endmodule

bind ldsp_top ldsp_top_properties ldsp_top_properties_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .frame_sel_n_i, .output_load_n_i, .fault_o, .analog_fault_i, .strap_i,
	.strap_o, .conv_value_o);

// [verif/test_ldsp_top.sv]
// Purpose: Self-checking bench of the loop converter serial port.
// Assumes: Bus and serial link are driven through tasks.
// Notes:   Loss of control count shortened to 400 cycles.
module test_ldsp_top
	import ldsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         wb_cyc_i = 1'b0;
	logic         wb_stb_i = 1'b0;
	logic         wb_we_i = 1'b0;
	logic [7:0]   wb_adr_i = 8'h00;
	logic [3:0]   wb_sel_i = 4'hF;
	logic [31:0]  wb_dat_i = 32'h0;
	logic [31:0]  wb_dat_o;
	logic [31:0]  rd;
	logic         wb_ack_o;
	logic         sclk;
	logic         fsel_n;
	logic         serial_data_in;
	logic         serial_data_out;
	logic         output_load_n_i = 1'b0;
	logic         fault_o;
	ldsp_analog_t analog_fault_i = '0;
	ldsp_strap_t  strap_i = 4'hB;
	ldsp_strap_t  strap_o;
	logic [15:0]  conv_value_o;
	int           err_count = 0;
	int           tests_run = 0;
	always #5 clk_i = ~clk_i;
	ldsp_top #(.LOSS_COUNT(400)) ldsp_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclk_i(sclk), .frame_sel_n_i(fsel_n),
		.serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out), .output_load_n_i, .fault_o, .analog_fault_i,
		.strap_i, .strap_o, .conv_value_o);
	ldsp_host_model ldsp_host_model_inst (.sclk_o(sclk), .frame_sel_n_o(fsel_n), .serial_data_in_o(serial_data_in),
		.serial_data_out_i(serial_data_out));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(what, e, rd & m);
	endtask
	task automatic give_verdict;
		$display("checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		give_verdict();
	end
	initial begin
		for (int s = 0; s < 2; s++) begin
			strap_i <= s ? 4'h4 : 4'hB;
			rst_i <= 1'b1;
			repeat (8) @(posedge clk_i);
			rst_i <= 1'b0;
			repeat (8) @(posedge clk_i);
			chk("strap_o", {28'h0, strap_i}, {28'h0, strap_o});
			rdchk("strap status", OFS_STATUS, 32'hF00, {20'h0, strap_i, 8'h0});
		end
		chk("fault idle", 32'h0, {31'h0, fault_o});
		rdchk("ctrl reset", OFS_CTRL, 32'h3, {30'h0, CTRL_RESET});
		rdchk("readback reset", OFS_READBACK, 32'hFFFF_FFFF, READBACK_RESET);
		rdchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_READBACK, 32'hA5C3_0F96);
		wb(1'b1, OFS_STATUS, 32'h1F);
		ldsp_host_model_inst.frame(32'h1234, 24, 17, 3, rd);
		repeat (10) @(posedge clk_i);
		chk("conv load low", 32'h1234, {16'h0, conv_value_o});
		output_load_n_i <= 1'b1;
		ldsp_host_model_inst.frame(32'hBEEF, 24, 50, 0, rd);
		chk("readback", 32'hA5C3_0F96 >> 9, {9'h0, rd[22:0]});
		repeat (10) @(posedge clk_i);
		chk("conv deferred", 32'h1234, {16'h0, conv_value_o});
		rdchk("pending", OFS_STATUS, 32'h2_0000, 32'h2_0000);
		rdchk("input reg", OFS_INPUT, 32'hFFFF, 32'hBEEF);
		rdchk("conv reg", OFS_CONV, 32'hFFFF, 32'h1234);
		rdchk("last frame", OFS_LASTFRAME, 32'hFF_FFFF, 32'hBEEF);
		rdchk("frame count", OFS_FRAMES, 32'hFFFF_FFFF, 32'h2);
		output_load_n_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk("conv load fall", 32'hBEEF, {16'h0, conv_value_o});
		ldsp_host_model_inst.frame(32'h55, 20, 17, 0, rd);
		repeat (10) @(posedge clk_i);
		chk("conv short frame", 32'hBEEF, {16'h0, conv_value_o});
		rdchk("frame error", OFS_STATUS, 32'h1_001F, 32'h1_0002);
		wb(1'b1, OFS_STATUS, 32'h1F);
		rdchk("cleared", OFS_STATUS, 32'h1_001F, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h1);
		ldsp_host_model_inst.frame(32'h0000_0001, 32, 17, 0, rd);
		ldsp_host_model_inst.frame(32'h0000_0000, 32, 17, 0, rd);
		repeat (10) @(posedge clk_i);
		chk("conv checked frame", 32'h0, {16'h0, conv_value_o});
		rdchk("checksum error", OFS_STATUS, 32'h1_001F, 32'h1_0002);
		rdchk("frame count pec", OFS_FRAMES, 32'hFFFF_FFFF, 32'h3);
		wb(1'b1, OFS_STATUS, 32'h1F);
		for (int i = 0; i < 3; i++) begin
			analog_fault_i <= ldsp_analog_t'(3'h1 << i);
			repeat (8) @(posedge clk_i);
			rdchk("analog flag", OFS_STATUS, 32'h1_001F, 32'h1_0000 | (32'h4 << i));
			analog_fault_i <= '0;
			repeat (4) @(posedge clk_i);
			wb(1'b1, OFS_STATUS, 32'h1F);
			rdchk("analog clear", OFS_STATUS, 32'h1_001F, 32'h0);
		end
		wb(1'b1, OFS_CTRL, 32'h2);
		repeat (450) @(posedge clk_i);
		rdchk("loss flag", OFS_STATUS, 32'h1_001F, 32'h1_0001);
		chk("fault pin", 32'h1, {31'h0, fault_o});
		give_verdict();
	end
endmodule
